// ==== core/pd_control.sv ====
// Process-data command interpreter for a heatsealing temperature controller
`timescale 1ns/100ps
`default_nettype none
module pd_control #(
  parameter longint LOCK_CYCLES = pd_pkg::LOCK_CYC,
  parameter longint CAL_CYCLES  = pd_pkg::CAL_CYC,
  parameter longint BLINK_HALF  = pd_pkg::BLINK_CYC
) (
  // Clock and reset
  input  wire logic                      CLK,
  input  wire logic                      RESET,
  // Incoming process data
  input  wire logic [pd_pkg::WORD_W-1:0] SETPOINT_WORD,
  input  wire logic [pd_pkg::WORD_W-1:0] CONTROL_WORD,
  // Parameters and plant condition
  input  wire logic                      VAR_CAL_ENABLE,
  input  wire logic                      PARAM_VALID,
  input  wire logic [8:0]                PARAM_CAL_TEMP,
  input  wire logic [pd_pkg::WORD_W-1:0] MEASURED_TEMP,
  input  wire logic                      COOLING_FAST,
  input  wire logic                      BAND_UNSTABLE,
  input  wire logic                      HEATING_INDICATOR_TIME_OVER,
  input  wire logic                      NET_ERROR,
  input  wire logic [pd_pkg::CODE_W-1:0] PLANT_FAULT_CODE,
  // Outgoing process data
  output var  logic [pd_pkg::WORD_W-1:0] ACTUAL_WORD,
  output var  logic [pd_pkg::WORD_W-1:0] STATUS_WORD,
  output var  logic [pd_pkg::WORD_W-1:0] FAULT_WORD,
  // Indicators and drives
  output var  logic                      ZERO_CALIBRATION_LED,
  output var  logic                      HEATING_INDICATOR,
  output var  logic                      ANALOG_ZERO,
  output var  logic                      HEATER_ENABLE,
  output var  logic [8:0]                CAL_TEMP_USED
);
  import pd_pkg::*;

  // Synchronised pins
  logic [WORD_W-1:0] sp_s1_r, sp_r, cw_s1_r, cw_r;
  logic [6:0]        fl_s1_r, fl_r;
  logic              calib_request, heating_indicator_request, fault_clear_request;
  logic              cool_fast, band_unstable, heating_indicator_over, net_err, var_cal, param_ok;
  logic [8:0]        setpoint;
  pd_blink_if        bl ();

  // Two-flop synchronisers on the set point, control word and flag pins
  always_ff @(posedge CLK) begin
    if (RESET) begin
      sp_s1_r <= '0;
      sp_r    <= '0;
      cw_s1_r <= '0;
      cw_r    <= '0;
      fl_s1_r <= '0;
      fl_r    <= '0;
    end else begin
      sp_s1_r <= SETPOINT_WORD;
      sp_r    <= sp_s1_r;
      cw_s1_r <= CONTROL_WORD;
      cw_r    <= cw_s1_r;
      fl_s1_r <= {PARAM_VALID, VAR_CAL_ENABLE, NET_ERROR, HEATING_INDICATOR_TIME_OVER,
                  BAND_UNSTABLE, COOLING_FAST, 1'b0};
      fl_r    <= fl_s1_r;
    end
  end

  // Field extraction; spare bits ignored
  assign setpoint            = sp_r[TEMP_W-1:0];
  assign calib_request       = cw_r[BIT_CALIB];
  assign heating_indicator_request        = cw_r[BIT_HEATING_INDICATOR];
  assign fault_clear_request = cw_r[BIT_CLEAR];
  assign cool_fast           = fl_r[1];
  assign band_unstable       = fl_r[2];
  assign heating_indicator_over           = fl_r[3];
  assign net_err             = fl_r[4];
  assign var_cal             = fl_r[5];
  assign param_ok            = fl_r[6];

  // Two-flop synchronisers on plant values and parameters
  logic [WORD_W-1:0] meas_s1_r, meas_r;
  logic [CODE_W-1:0] pf_s1_r, pf_r;
  logic [8:0]        pcal_s1_r, pcal_r;
  always_ff @(posedge CLK) begin
    if (RESET) begin
      meas_s1_r <= '0;
      meas_r    <= '0;
      pf_s1_r   <= '0;
      pf_r      <= '0;
      pcal_s1_r <= '0;
      pcal_r    <= '0;
    end else begin
      meas_s1_r <= MEASURED_TEMP;
      meas_r    <= meas_s1_r;
      pf_s1_r   <= PLANT_FAULT_CODE;
      pf_r      <= pf_s1_r;
      pcal_s1_r <= PARAM_CAL_TEMP;
      pcal_r    <= pcal_s1_r;
    end
  end

  // Fault code blocking, by startup or after a good run
  function automatic logic blocks_cal(input logic [CODE_W-1:0] c, input logic good);
    logic grp2, grp8, grp9, grp1;
    grp1 = (c >= 10'd101) && (c <= 10'd103);
    grp2 = (c >= 10'd201) && (c <= 10'd203);
    grp8 = (c == 10'd801);
    grp9 = (c >= 10'd900) && (c <= 10'd999);
    return grp2 || grp8 || grp9 || (grp1 && !good);
  endfunction : blocks_cal

  // Power-on lockout counter
  logic [CNT_W-1:0] lock_cnt_r;
  logic             lock_done_r;
  always_ff @(posedge CLK) begin
    if (RESET) begin
      lock_cnt_r  <= '0;
      lock_done_r <= 1'b0;
    end else if (!lock_done_r) begin
      lock_cnt_r  <= lock_cnt_r + 1'b1;
      lock_done_r <= (lock_cnt_r == CNT_W'(LOCK_CYCLES - 1));
    end
  end

  // Control state
  mode_t            mode_r;
  logic [CNT_W-1:0] cal_cnt_r;
  logic [1:0]       tries_r;
  logic [8:0]       cal_temp_r;
  logic [CODE_W-1:0] own_err_r;
  logic             good_run_r;
  logic             fault;
  logic             cal_locked;
  logic             heating_indicator_allowed;
  logic [8:0]       cal_src;

  assign fault      = (own_err_r != ERR_NONE) || (pf_r != ERR_NONE);
  assign cal_src    = var_cal ? setpoint : (param_ok ? pcal_r : CAL_DEFAULT_C);
  assign cal_locked = !lock_done_r || cool_fast || heating_indicator_request
                      || fault_clear_request
                      || blocks_cal(pf_r, good_run_r);
  assign heating_indicator_allowed = !fault && !fault_clear_request &&
                        ({1'b0, setpoint} >= {1'b0, cal_temp_r} + HEATING_INDICATOR_MARGIN_C);

  // Calibration and heating_indicator sequencer
  always_ff @(posedge CLK) begin
    if (RESET) begin
      mode_r     <= S_IDLE;
      cal_cnt_r  <= '0;
      tries_r    <= '0;
      cal_temp_r <= CAL_DEFAULT_C;
    end else begin
      case (mode_r)
        S_IDLE: begin
          cal_cnt_r <= '0;
          tries_r   <= '0;
          if (calib_request && !cal_locked && !fault) begin
            if (!(var_cal && setpoint > CAL_MAX_C)) begin
              mode_r     <= S_CAL;
              cal_temp_r <= cal_src;
            end
          end else if (heating_indicator_request && !calib_request && heating_indicator_allowed && !net_err) begin
            mode_r <= S_HEATING_INDICATOR;
          end
        end
        S_CAL: begin
          // Drift in the supplied temperature aborts the run
          if (var_cal && setpoint != cal_temp_r) begin
            mode_r <= S_IDLE;
          end else if (band_unstable) begin
            cal_cnt_r <= '0;
            if (tries_r == 2'(CAL_TRIES - 1)) begin
              mode_r <= S_IDLE;
            end else begin
              tries_r <= tries_r + 1'b1;
            end
          end else if (cal_cnt_r == CNT_W'(CAL_CYCLES - 1)) begin
            mode_r <= S_IDLE;
          end else begin
            cal_cnt_r <= cal_cnt_r + 1'b1;
          end
        end
        S_HEATING_INDICATOR: begin
          if (!heating_indicator_request || net_err || heating_indicator_over || fault) begin
            mode_r <= S_IDLE;
          end
        end
        default: mode_r <= S_IDLE;
      endcase
    end
  end

  // Own fault codes, cleared by the fault clear request
  always_ff @(posedge CLK) begin
    if (RESET) begin
      own_err_r <= ERR_NONE;
    end else if (mode_r == S_IDLE && calib_request && !cal_locked && !fault
                 && var_cal && setpoint > CAL_MAX_C) begin
      own_err_r <= ERR_CAL_RANGE;
    end else if (mode_r == S_CAL && var_cal && setpoint != cal_temp_r) begin
      own_err_r <= ERR_CAL_DRIFT;
    end else if (mode_r == S_CAL && band_unstable && tries_r == 2'(CAL_TRIES - 1)) begin
      own_err_r <= ERR_CAL_FAIL;
    end else if (mode_r == S_HEATING_INDICATOR && heating_indicator_request && heating_indicator_over) begin
      own_err_r <= ERR_HEATING_INDICATOR_TIME;
    end else if (fault_clear_request) begin
      own_err_r <= ERR_NONE;
    end
  end

  // Good run marker after a completed fault-free heating_indicator cycle
  always_ff @(posedge CLK) begin
    if (RESET) begin
      good_run_r <= 1'b0;
    end else if (mode_r == S_HEATING_INDICATOR && !heating_indicator_request && !fault) begin
      good_run_r <= 1'b1;
    end
  end

  // Blink divider
  pd_blink #(.HALF_CYC(BLINK_HALF)) u_blink (
    .clk   (CLK),
    .reset (RESET),
    .bl    (bl)
  );

  // Outgoing words and indicators
  always_ff @(posedge CLK) begin
    if (RESET) begin
      ACTUAL_WORD          <= '0;
      STATUS_WORD          <= '0;
      FAULT_WORD           <= '0;
      ZERO_CALIBRATION_LED <= 1'b0;
      HEATING_INDICATOR    <= 1'b0;
      ANALOG_ZERO          <= 1'b0;
      HEATER_ENABLE        <= 1'b0;
      CAL_TEMP_USED        <= CAL_DEFAULT_C;
    end else begin
      ACTUAL_WORD <= (mode_r == S_CAL || fault) ? '0 : meas_r;
      STATUS_WORD <= '0;
      STATUS_WORD[ST_RUNNING]    <= (mode_r == S_CAL);
      STATUS_WORD[ST_LOCKED]     <= cal_locked;
      STATUS_WORD[ST_FAULT]      <= fault;
      STATUS_WORD[ST_REGULATING] <= (mode_r == S_HEATING_INDICATOR);
      FAULT_WORD <= {6'h00, own_err_r != ERR_NONE ? own_err_r : pf_r};
      ZERO_CALIBRATION_LED <= (mode_r == S_CAL) ||
                              (calib_request && cal_locked && bl.phase);
      HEATING_INDICATOR <= (mode_r == S_HEATING_INDICATOR) ||
                           (heating_indicator_request && mode_r != S_HEATING_INDICATOR && bl.phase);
      ANALOG_ZERO   <= (mode_r == S_CAL);
      HEATER_ENABLE <= (mode_r == S_HEATING_INDICATOR);
      CAL_TEMP_USED <= cal_temp_r;
    end
  end

  // Checks
  property p_cal_flag;
    @(posedge CLK) disable iff (RESET)
      (mode_r == S_CAL) |=> STATUS_WORD[ST_RUNNING] && ANALOG_ZERO && !HEATER_ENABLE;
  endproperty
  a_cal_flag: assert property (p_cal_flag) else $error("calibration flags wrong");

  property p_lock_early;
    @(posedge CLK) disable iff (RESET)
      !lock_done_r |-> mode_r != S_CAL;
  endproperty
  a_lock_early: assert property (p_lock_early) else $error("calibration during lockout");

  property p_no_cal_heating_indicator;
    @(posedge CLK) disable iff (RESET)
      (mode_r == S_IDLE && heating_indicator_request) |=> mode_r != S_CAL;
  endproperty
  a_no_cal_heating_indicator: assert property (p_no_cal_heating_indicator) else $error("calibration with heating_indicator");

  property p_actual_zero;
    @(posedge CLK) disable iff (RESET)
      (mode_r == S_CAL || fault) |=> ACTUAL_WORD == '0;
  endproperty
  a_actual_zero: assert property (p_actual_zero) else $error("actual value not zero");

  property p_heating_indicator_end;
    @(posedge CLK) disable iff (RESET)
      (mode_r == S_HEATING_INDICATOR && (!heating_indicator_request || net_err)) |=> mode_r == S_IDLE;
  endproperty
  a_heating_indicator_end: assert property (p_heating_indicator_end) else $error("heating_indicator-up not ended");

  property p_heating_indicator_led;
    @(posedge CLK) disable iff (RESET)
      (mode_r == S_HEATING_INDICATOR) |=> HEATING_INDICATOR;
  endproperty
  a_heating_indicator_led: assert property (p_heating_indicator_led) else $error("heating_indicator indicator dark");

  property p_range_err;
    @(posedge CLK) disable iff (RESET)
      (mode_r == S_IDLE && calib_request && !cal_locked && !fault && var_cal
       && setpoint > CAL_MAX_C) |=> own_err_r == ERR_CAL_RANGE && mode_r == S_IDLE;
  endproperty
  a_range_err: assert property (p_range_err) else $error("range fault missing");

  property p_heating_indicator_refuse;
    @(posedge CLK) disable iff (RESET)
      (mode_r == S_IDLE && fault_clear_request) |=> mode_r == S_IDLE;
  endproperty
  a_heating_indicator_refuse: assert property (p_heating_indicator_refuse) else $error("request taken under clear");

  property p_fault_word;
    @(posedge CLK) disable iff (RESET)
      (own_err_r != ERR_NONE) |=> FAULT_WORD[CODE_W-1:0] == $past(own_err_r);
  endproperty
  a_fault_word: assert property (p_fault_word) else $error("fault code mismatch");

  property p_blink_edge;
    @(posedge CLK) disable iff (RESET)
      bl.tick |-> bl.phase != $past(bl.phase);
  endproperty
  a_blink_edge: assert property (p_blink_edge) else $error("blink phase stuck");

  property p_heating_indicator_gate;
    @(posedge CLK) disable iff (RESET)
      (mode_r == S_IDLE && !heating_indicator_allowed) |=> mode_r != S_HEATING_INDICATOR;
  endproperty
  a_heating_indicator_gate: assert property (p_heating_indicator_gate) else $error("heating_indicator taken while refused");
endmodule : pd_control
`default_nettype wire

// ==== core/pd_pkg.sv ====
// Package with constants and types for the process-data control block
package pd_pkg;
  // Word layout
  localparam int WORD_W        = 16;
  localparam int TEMP_W        = 9;
  localparam int CODE_W        = 10;
  localparam int BIT_CALIB     = 0;
  localparam int BIT_HEATING_INDICATOR      = 1;
  localparam int BIT_CLEAR     = 2;
  localparam int BIT_PAUSE     = 3;
  // Status word bit positions
  localparam int ST_RUNNING    = 0;
  localparam int ST_LOCKED     = 1;
  localparam int ST_FAULT      = 2;
  localparam int ST_REGULATING = 7;
  // Temperatures in degrees C
  localparam logic [8:0] CAL_DEFAULT_C = 9'h014;
  localparam logic [8:0] CAL_MAX_C     = 9'h028;
  localparam logic [9:0] HEATING_INDICATOR_MARGIN_C = 10'h014;
  // Fault codes
  localparam logic [9:0] ERR_CAL_RANGE = 10'h073;
  localparam logic [9:0] ERR_CAL_DRIFT = 10'h074;
  localparam logic [9:0] ERR_CAL_FAIL  = 10'h075;
  localparam logic [9:0] ERR_HEATING_INDICATOR_TIME = 10'h132;
  localparam logic [9:0] ERR_NONE      = 10'h000;
  // Times and rates
  localparam longint CLK_HZ        = 10000000;
  localparam longint LOCK_MS       = 10000;
  localparam longint CAL_MS        = 12000;
  localparam longint BLINK_HZ      = 4;
  localparam longint LOCK_CYC      = (CLK_HZ / 1000) * LOCK_MS;
  localparam longint CAL_CYC       = (CLK_HZ / 1000) * CAL_MS;
  localparam longint BLINK_CYC     = CLK_HZ / (2 * BLINK_HZ);
  localparam int     CAL_TRIES     = 3;
  localparam int     CNT_W         = 32;
  // Calibration / heating_indicator control states
  typedef enum logic [1:0] {
    S_IDLE  = 2'b00,
    S_CAL   = 2'b01,
    S_HEATING_INDICATOR  = 2'b10
  } mode_t;
endpackage : pd_pkg

// ==== core/pd_blink_if.sv ====
// Interface carrying blink timing between top and blink divider
`timescale 1ns/100ps
`default_nettype none
interface pd_blink_if;
  logic tick;
  logic phase;
  modport src (output tick, output phase);
  modport dst (input tick, input phase);
endinterface : pd_blink_if
`default_nettype wire

// ==== core/pd_blink.sv ====
// Divider giving the 4 Hz blink phase for indicators
`timescale 1ns/100ps
`default_nettype none
module pd_blink #(
  parameter longint HALF_CYC = pd_pkg::BLINK_CYC
) (
  // Clock and reset
  input wire logic  clk,
  input wire logic  reset,
  // Blink outputs
  pd_blink_if.src   bl
);
  import pd_pkg::*;
  logic [CNT_W-1:0] cnt_r;
  logic             phase_r;
  logic             tick_r;

  // Half-period counter toggling the phase
  always_ff @(posedge clk) begin
    if (reset) begin
      cnt_r   <= '0;
      phase_r <= 1'b0;
      tick_r  <= 1'b0;
    end else if (cnt_r == CNT_W'(HALF_CYC - 1)) begin
      cnt_r   <= '0;
      phase_r <= ~phase_r;
      tick_r  <= 1'b1;
    end else begin
      cnt_r   <= cnt_r + 1'b1;
      tick_r  <= 1'b0;
    end
  end
  assign bl.tick  = tick_r;
  assign bl.phase = phase_r;
endmodule : pd_blink
`default_nettype wire

// ==== testbench/pd_scanner.sv ====
// Scanner-side model driving the two cyclic input words
`timescale 1ns/100ps
`default_nettype none
module pd_scanner (
  // Requests from the test sequence
  input  wire logic [8:0]  set_temp,
  input  wire logic [3:0]  req,
  input  wire logic        spare_on,
  // Cyclic words towards the controller
  output var  logic [15:0] sp_word,
  output var  logic [15:0] ctl_word
);
  // Set point held exactly as the sequence gives it; spares zero unless noise is asked for
  always_comb begin
    sp_word  = {(spare_on ? 7'h55 : 7'h00), set_temp};
    ctl_word = {(spare_on ? 12'ha5a : 12'h000), req};
  end
endmodule : pd_scanner
`default_nettype wire

// ==== testbench/tb.sv ====
// Self-checking bench for the process-data control block
`timescale 1ns/100ps
`default_nettype none
module tb;
  import pd_pkg::*;
  // Design ports and scanner requests
  logic        CLK, RESET, VAR_CAL_ENABLE, PARAM_VALID, COOLING_FAST, BAND_UNSTABLE;
  logic        HEATING_INDICATOR_TIME_OVER, NET_ERROR, ZERO_CALIBRATION_LED, HEATING_INDICATOR;
  logic        ANALOG_ZERO, HEATER_ENABLE, spare_on;
  logic [8:0]  PARAM_CAL_TEMP, CAL_TEMP_USED, set_temp;
  logic [9:0]  PLANT_FAULT_CODE;
  logic [15:0] SETPOINT_WORD, CONTROL_WORD, MEASURED_TEMP;
  logic [15:0] ACTUAL_WORD, STATUS_WORD, FAULT_WORD;
  logic [3:0]  req;
  int          err_total, cmp_count, n, c;

  // Clock at 10 MHz
  always #50 CLK = ~CLK;

  pd_scanner scan (.set_temp(set_temp), .req(req), .spare_on(spare_on),
    .sp_word(SETPOINT_WORD), .ctl_word(CONTROL_WORD));

  pd_control #(.LOCK_CYCLES(60), .CAL_CYCLES(50), .BLINK_HALF(4)) dut (
    .CLK(CLK), .RESET(RESET), .SETPOINT_WORD(SETPOINT_WORD), .CONTROL_WORD(CONTROL_WORD),
    .VAR_CAL_ENABLE(VAR_CAL_ENABLE), .PARAM_VALID(PARAM_VALID),
    .PARAM_CAL_TEMP(PARAM_CAL_TEMP), .MEASURED_TEMP(MEASURED_TEMP),
    .COOLING_FAST(COOLING_FAST), .BAND_UNSTABLE(BAND_UNSTABLE),
    .HEATING_INDICATOR_TIME_OVER(HEATING_INDICATOR_TIME_OVER), .NET_ERROR(NET_ERROR),
    .PLANT_FAULT_CODE(PLANT_FAULT_CODE), .ACTUAL_WORD(ACTUAL_WORD),
    .STATUS_WORD(STATUS_WORD), .FAULT_WORD(FAULT_WORD),
    .ZERO_CALIBRATION_LED(ZERO_CALIBRATION_LED), .HEATING_INDICATOR(HEATING_INDICATOR),
    .ANALOG_ZERO(ANALOG_ZERO), .HEATER_ENABLE(HEATER_ENABLE), .CAL_TEMP_USED(CAL_TEMP_USED));

  // Summary and verdict, then stop
  task automatic end_sim();
    $display("checks %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_sim

  // Compare seen against expected
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // Pass falling edges
  task automatic cyc(input int k);
    repeat (k) @(negedge CLK);
  endtask : cyc

  // Bounded wait for a status bit, returning the cycles spent
  task automatic wait_bit(input int b, input logic v, input int lim, output int i);
    i = 0;
    while (STATUS_WORD[b] !== v && i < lim) begin
      @(negedge CLK);
      i++;
    end
    if (STATUS_WORD[b] !== v) begin
      chk(16'(STATUS_WORD[b]), 16'(v));
      end_sim();
    end
  endtask : wait_bit

  // Count indicator changes over 20 cycles
  task automatic cnt(input bit heating_indicator, output int k);
    logic p;
    k = 0;
    p = heating_indicator ? HEATING_INDICATOR : ZERO_CALIBRATION_LED;
    repeat (20) begin
      @(negedge CLK);
      if ((heating_indicator ? HEATING_INDICATOR : ZERO_CALIBRATION_LED) !== p) k++;
      p = heating_indicator ? HEATING_INDICATOR : ZERO_CALIBRATION_LED;
    end
  endtask : cnt

  // Fault clear with calibrate also asked, which must not start
  task automatic clr();
    req = 4'h5;
    cyc(8);
    chk(16'(STATUS_WORD[ST_RUNNING]), 16'h0);
    req = 4'h0;
    cyc(6);
    chk(FAULT_WORD, 16'h0000);
  endtask : clr

  // Main sequence
  initial begin
    CLK = 0; RESET = 1; VAR_CAL_ENABLE = 0; PARAM_VALID = 0; COOLING_FAST = 0;
    BAND_UNSTABLE = 0; HEATING_INDICATOR_TIME_OVER = 0; NET_ERROR = 0; PARAM_CAL_TEMP = 9'h000;
    PLANT_FAULT_CODE = 10'h000; MEASURED_TEMP = 16'h0000; set_temp = 9'h000;
    req = 4'h0; spare_on = 0; err_total = 0; cmp_count = 0;
    repeat (20) @(negedge CLK);
    RESET = 0;
    cyc(3);
    chk(16'(STATUS_WORD[ST_LOCKED]), 16'h1);
    req = 4'h1;
    cyc(4);
    cnt(0, c);
    chk(16'(c >= 3), 16'h1);
    chk(16'(STATUS_WORD[ST_RUNNING]), 16'h0);
    req = 4'h0;
    wait_bit(ST_LOCKED, 0, 80, n);
    $display("test lockout done");
    spare_on = 1;
    MEASURED_TEMP = 16'hfff6;
    cyc(6);
    chk(ACTUAL_WORD, 16'hfff6);
    req = 4'h1;
    wait_bit(ST_RUNNING, 1, 8, n);
    req = 4'h0;
    cyc(1);
    chk(16'({ZERO_CALIBRATION_LED, ANALOG_ZERO, HEATER_ENABLE}), 16'h6);
    chk(STATUS_WORD, 16'h0001);
    chk(ACTUAL_WORD, 16'h0000);
    chk(16'(CAL_TEMP_USED), 16'(CAL_DEFAULT_C));
    wait_bit(ST_RUNNING, 0, 200, n);
    chk(16'(n >= 45 && n <= 55), 16'h1);
    $display("test calibrate done");
    set_temp = 9'h027;
    req = 4'h2;
    cyc(4);
    cnt(1, c);
    chk(16'(c >= 3), 16'h1);
    chk(16'(HEATER_ENABLE), 16'h0);
    set_temp = 9'h028;
    wait_bit(ST_REGULATING, 1, 8, n);
    chk(16'(HEATER_ENABLE), 16'h1);
    cyc(1);
    cnt(1, c);
    chk(16'({c[3:0], HEATING_INDICATOR}), 16'h1);
    req = 4'h3;
    cyc(8);
    chk(16'(STATUS_WORD[ST_RUNNING]), 16'h0);
    NET_ERROR = 1;
    wait_bit(ST_REGULATING, 0, 8, n);
    chk(16'(HEATER_ENABLE), 16'h0);
    NET_ERROR = 0;
    req = 4'h0;
    cyc(4);
    req = 4'h2;
    wait_bit(ST_REGULATING, 1, 8, n);
    HEATING_INDICATOR_TIME_OVER = 1;
    wait_bit(ST_REGULATING, 0, 8, n);
    HEATING_INDICATOR_TIME_OVER = 0;
    cyc(8);
    chk(FAULT_WORD, 16'(ERR_HEATING_INDICATOR_TIME));
    chk(16'(STATUS_WORD[ST_FAULT]), 16'h1);
    chk(16'(STATUS_WORD[ST_REGULATING]), 16'h0);
    clr();
    $display("test heating_indicator done");
    PLANT_FAULT_CODE = 10'h0c9;
    req = 4'h1;
    cyc(8);
    chk(16'(STATUS_WORD[ST_RUNNING]), 16'h0);
    chk(FAULT_WORD, 16'h00c9);
    PLANT_FAULT_CODE = 10'h000;
    clr();
    COOLING_FAST = 1;
    req = 4'h1;
    cyc(10);
    chk(16'(STATUS_WORD[ST_RUNNING]), 16'h0);
    COOLING_FAST = 0;
    wait_bit(ST_RUNNING, 1, 8, n);
    req = 4'h0;
    wait_bit(ST_RUNNING, 0, 200, n);
    $display("test blocking done");
    VAR_CAL_ENABLE = 1;
    set_temp = 9'h01e;
    req = 4'h1;
    wait_bit(ST_RUNNING, 1, 8, n);
    req = 4'h0;
    cyc(1);
    chk(16'(CAL_TEMP_USED), 16'h001e);
    set_temp = 9'h01f;
    wait_bit(ST_FAULT, 1, 8, n);
    chk(FAULT_WORD, 16'(ERR_CAL_DRIFT));
    clr();
    set_temp = 9'h029;
    req = 4'h1;
    wait_bit(ST_FAULT, 1, 8, n);
    chk(FAULT_WORD, 16'(ERR_CAL_RANGE));
    chk(ACTUAL_WORD, 16'h0000);
    clr();
    VAR_CAL_ENABLE = 0;
    PARAM_VALID = 1;
    PARAM_CAL_TEMP = 9'h019;
    req = 4'h1;
    wait_bit(ST_RUNNING, 1, 8, n);
    req = 4'h0;
    cyc(1);
    chk(16'(CAL_TEMP_USED), 16'h0019);
    BAND_UNSTABLE = 1;
    cyc(4);
    BAND_UNSTABLE = 0;
    wait_bit(ST_FAULT, 1, 20, n);
    chk(FAULT_WORD, 16'(ERR_CAL_FAIL));
    clr();
    $display("test calibration temperature done");
    PLANT_FAULT_CODE = 10'h065;
    cyc(6);
    chk(16'(STATUS_WORD[ST_LOCKED]), 16'h1);
    PLANT_FAULT_CODE = 10'h000;
    set_temp = 9'h02d;
    req = 4'h2;
    wait_bit(ST_REGULATING, 1, 8, n);
    req = 4'h0;
    wait_bit(ST_REGULATING, 0, 8, n);
    PLANT_FAULT_CODE = 10'h065;
    cyc(6);
    chk(16'(STATUS_WORD[ST_LOCKED]), 16'h0);
    PLANT_FAULT_CODE = 10'h000;
    $display("test good run done");
    end_sim();
  end
endmodule : tb
`default_nettype wire
